// ### verilog/tce_pkg.sv
// Constants, field layouts and carrier types of the timer control block.
// Assumes a single 200 MHz clock and a plain strobe-based register port.
package tce_pkg;

	localparam int TCE_AW = 8;
	localparam int TCE_DW = 32;

	localparam logic [TCE_AW-1:0] TCE_OFS_CNT_LO = 8'h10;
	localparam logic [TCE_AW-1:0] TCE_OFS_CNT_HI = 8'h14;
	localparam logic [TCE_AW-1:0] TCE_OFS_PRD_LO = 8'h18;
	localparam logic [TCE_AW-1:0] TCE_OFS_PRD_HI = 8'h1C;
	localparam logic [TCE_AW-1:0] TCE_OFS_CTRL = 8'h20;
	localparam logic [TCE_AW-1:0] TCE_OFS_GCTRL = 8'h24;

	// Control and global control register field positions
	localparam int TCE_B_UPPER_EN = 22;
	localparam int TCE_B_SRC = 8;
	localparam int TCE_B_LOWER_EN = 6;
	localparam int TCE_B_OUTPUT_PULSE_WIDTH = 4;
	localparam int TCE_B_CP = 3;
	localparam int TCE_B_INVIN = 2;
	localparam int TCE_B_INVOUT = 1;
	localparam int TCE_B_STAT = 0;
	localparam int TCE_B_GMODE = 2;

	localparam logic [31:0] TCE_PRD_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		TCE_EN_OFF = 2'b00,
		TCE_EN_ONCE = 2'b01,
		TCE_EN_CONT = 2'b10,
		TCE_EN_RSVD = 2'b11
	} tce_ena_t;

	typedef enum logic [1:0] {
		TCE_GM_64 = 2'b00,
		TCE_GM_UNCH = 2'b01,
		TCE_GM_RSVD = 2'b10,
		TCE_GM_CHAIN = 2'b11
	} tce_gmode_t;

	typedef struct packed {
		tce_ena_t upper_half_enable_select;
		logic lower_count_source_select;
		tce_ena_t lower_half_enable_select;
		logic [1:0] output_pulse_width;
		logic output_clock_or_pulse;
		logic input_invert;
		logic output_invert;
	} tce_ctrl_t;

	localparam tce_ctrl_t TCE_CTRL_RESET = '{TCE_EN_OFF, 1'b0, TCE_EN_OFF, 2'b00, 1'b0, 1'b0, 1'b0};

	typedef struct packed {
		logic [TCE_AW-1:0] addr;
		logic [TCE_DW-1:0] wdata;
		logic wr;
		logic rd;
	} tce_bus_t;

	typedef struct packed {
		logic [63:0] cnt;
		logic done;
		logic hit;
	} tce_step_t;

endpackage

// ### verilog/tce_sync.sv
// Two-flop synchroniser for the timer input pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tce_sync
	import tce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
	} tce_sync_st_t;

	tce_sync_st_t st;
	tce_sync_st_t next_st;

	always_comb begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.s2;
endmodule
`default_nettype wire

// ### verilog/tce_outgen.sv
// Timer output former: pulse of programmable width or square wave.
// Assumes hit and tick are one-cycle pulses on clk; hit coincides with a tick.
`timescale 1ns/1ps
`default_nettype none
module tce_outgen
	import tce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hit,
	input wire logic tick,
	input wire logic clock_mode,
	input wire logic [1:0] width,
	output logic level
);
	typedef struct packed {
		logic level;
		logic [1:0] remain;
	} tce_og_st_t;

	tce_og_st_t st;
	tce_og_st_t next_st;

	always_comb begin
		next_st = st;
		if (clock_mode) begin
			next_st.remain = 2'h0;
			if (hit) begin
				next_st.level = !st.level;
			end
		end else if (hit) begin
			next_st.level = 1'b1;
			next_st.remain = width;
		end else if (st.level && tick) begin
			if (st.remain == 2'h0) begin
				next_st.level = 1'b0;
			end else begin
				next_st.remain = st.remain - 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
endmodule
`default_nettype wire

// ### verilog/tce_top.sv
// Timer control block: control registers, two 32-bit count halves, output former.
// Assumes a same-clock register master and an asynchronous timer input pin.
`timescale 1ns/1ps
`default_nettype none
module tce_top
	import tce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire tce_bus_t bus,
	output logic [TCE_DW-1:0] rdata,
	input wire logic timer_in,
	output logic timer_out,
	output logic output_level_status
);
	typedef struct packed {
		tce_ctrl_t ctrl;
		tce_gmode_t gmode;
		logic [31:0] cnt_lo;
		logic [31:0] cnt_hi;
		logic [31:0] prd_lo;
		logic [31:0] prd_hi;
		logic done_lo;
		logic done_hi;
		logic pin_prev;
		logic [TCE_DW-1:0] rdata;
	} tce_st_t;

	tce_st_t st;
	tce_st_t next_st;
	logic pin_sync;
	logic pin_src;
	logic tick_lo;
	logic hit;
	logic level;
	logic pin_level;
	tce_ena_t mode_lo;
	tce_ena_t mode_hi;
	tce_step_t s64;
	tce_step_t slo;
	tce_step_t shi;

	function automatic tce_step_t tce_step(
		input logic [63:0] c,
		input logic [63:0] p,
		input tce_ena_t m,
		input logic d,
		input logic t
	);
		tce_step_t r;
		r.cnt = c;
		r.done = d;
		r.hit = 1'b0;
		if (t && !d) begin
			case (m)
				TCE_EN_ONCE: begin
					if (c == p) begin
						r.done = 1'b1;
					end else begin
						r.cnt = 64'(c + 64'h1);
						r.hit = (r.cnt == p);
						r.done = r.hit;
					end
				end
				TCE_EN_CONT: begin
					if (c == p) begin
						r.cnt = 64'h0;
					end else begin
						r.cnt = 64'(c + 64'h1);
						r.hit = (r.cnt == p);
					end
				end
				default: begin
					r.cnt = c;
				end
			endcase
		end
		return r;
	endfunction

	tce_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(timer_in),
		.dout(pin_sync)
	);

	// Count source of the lower half
	assign pin_src = pin_sync ^ st.ctrl.input_invert;
	assign tick_lo = st.ctrl.lower_count_source_select ? (pin_src && !st.pin_prev) : 1'b1;

	always_comb begin
		mode_lo = st.ctrl.lower_half_enable_select;
		mode_hi = TCE_EN_OFF;
		case (st.gmode)
			TCE_GM_UNCH: begin
				mode_hi = st.ctrl.upper_half_enable_select;
			end
			TCE_GM_CHAIN: begin
				mode_hi = st.ctrl.lower_half_enable_select;
				mode_lo = (mode_hi == TCE_EN_ONCE || mode_hi == TCE_EN_CONT) ? TCE_EN_CONT : TCE_EN_OFF;
			end
			TCE_GM_64: begin
				mode_hi = TCE_EN_OFF;
			end
			default: begin
				mode_lo = TCE_EN_OFF;
			end
		endcase
	end

	assign s64 = tce_step({st.cnt_hi, st.cnt_lo}, {st.prd_hi, st.prd_lo}, mode_lo, st.done_lo, tick_lo);
	assign slo = tce_step({32'h0, st.cnt_lo}, {32'h0, st.prd_lo}, mode_lo, st.done_lo, tick_lo);
	assign shi = tce_step({32'h0, st.cnt_hi}, {32'h0, st.prd_hi}, mode_hi, st.done_hi,
		(st.gmode == TCE_GM_CHAIN) ? slo.hit : 1'b1);

	// Period match that forms the timer output
	always_comb begin
		case (st.gmode)
			TCE_GM_64: hit = s64.hit;
			TCE_GM_UNCH: hit = slo.hit;
			TCE_GM_CHAIN: hit = shi.hit;
			default: hit = 1'b0;
		endcase
	end

	tce_outgen u_outgen (
		.clk(clk),
		.rst_n(rst_n),
		.hit(hit),
		.tick(tick_lo),
		.clock_mode(st.ctrl.output_clock_or_pulse),
		.width(st.ctrl.output_pulse_width),
		.level(level)
	);

	// Inversion bit low means inverted
	assign pin_level = level ^ !st.ctrl.output_invert;

	always_comb begin
		next_st = st;
		next_st.pin_prev = pin_src;
		next_st.rdata = '0;
		if (st.gmode == TCE_GM_64) begin
			next_st.cnt_lo = s64.cnt[31:0];
			next_st.cnt_hi = s64.cnt[63:32];
			next_st.done_lo = s64.done;
		end else begin
			next_st.cnt_lo = slo.cnt[31:0];
			next_st.done_lo = (st.gmode == TCE_GM_CHAIN) ? 1'b0 : slo.done;
			next_st.cnt_hi = shi.cnt[31:0];
			next_st.done_hi = shi.done;
			if (st.gmode == TCE_GM_CHAIN) begin
				next_st.done_lo = shi.done;
			end
		end
		if (bus.wr) begin
			case (bus.addr)
				TCE_OFS_CNT_LO: next_st.cnt_lo = bus.wdata;
				TCE_OFS_CNT_HI: next_st.cnt_hi = bus.wdata;
				TCE_OFS_PRD_LO: next_st.prd_lo = bus.wdata;
				TCE_OFS_PRD_HI: next_st.prd_hi = bus.wdata;
				TCE_OFS_CTRL: begin
					next_st.ctrl.upper_half_enable_select = tce_ena_t'(bus.wdata[TCE_B_UPPER_EN +: 2]);
					next_st.ctrl.lower_count_source_select = bus.wdata[TCE_B_SRC];
					next_st.ctrl.lower_half_enable_select = tce_ena_t'(bus.wdata[TCE_B_LOWER_EN +: 2]);
					next_st.ctrl.output_pulse_width = bus.wdata[TCE_B_OUTPUT_PULSE_WIDTH +: 2];
					next_st.ctrl.output_clock_or_pulse = bus.wdata[TCE_B_CP];
					next_st.ctrl.input_invert = bus.wdata[TCE_B_INVIN];
					next_st.ctrl.output_invert = bus.wdata[TCE_B_INVOUT];
					next_st.done_lo = 1'b0;
					next_st.done_hi = 1'b0;
				end
				TCE_OFS_GCTRL: next_st.gmode = tce_gmode_t'(bus.wdata[TCE_B_GMODE +: 2]);
				default: next_st.rdata = '0;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				TCE_OFS_CNT_LO: next_st.rdata = st.cnt_lo;
				TCE_OFS_CNT_HI: next_st.rdata = st.cnt_hi;
				TCE_OFS_PRD_LO: next_st.rdata = st.prd_lo;
				TCE_OFS_PRD_HI: next_st.rdata = st.prd_hi;
				TCE_OFS_CTRL: begin
					next_st.rdata[TCE_B_UPPER_EN +: 2] = st.ctrl.upper_half_enable_select;
					next_st.rdata[TCE_B_SRC] = st.ctrl.lower_count_source_select;
					next_st.rdata[TCE_B_LOWER_EN +: 2] = st.ctrl.lower_half_enable_select;
					next_st.rdata[TCE_B_OUTPUT_PULSE_WIDTH +: 2] = st.ctrl.output_pulse_width;
					next_st.rdata[TCE_B_CP] = st.ctrl.output_clock_or_pulse;
					next_st.rdata[TCE_B_INVIN] = st.ctrl.input_invert;
					next_st.rdata[TCE_B_INVOUT] = st.ctrl.output_invert;
					next_st.rdata[TCE_B_STAT] = pin_level;
				end
				TCE_OFS_GCTRL: next_st.rdata[TCE_B_GMODE +: 2] = st.gmode;
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{TCE_CTRL_RESET, TCE_GM_64, 32'h0, 32'h0, TCE_PRD_RESET, TCE_PRD_RESET,
				1'b0, 1'b0, 1'b0, 32'h0};
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign timer_out = pin_level;
	assign output_level_status = pin_level;
endmodule
`default_nettype wire

// ### testbench/tce_asserts.sv
// Port-level checker for the timer control block.
// Assumes it is bound to tce_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tce_chk
	import tce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire tce_bus_t bus,
	input wire logic [TCE_DW-1:0] rdata,
	input wire logic timer_in,
	input wire logic timer_out,
	input wire logic output_level_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] sh;
	logic [31:0] sd;
	logic [2:0] hi;
	logic gen;
	assign gen = timer_out ^ ~sh[1];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh <= '0;
			sd <= '0;
			hi <= '0;
		end else begin
			sh <= (bus.wr && bus.addr == TCE_OFS_CTRL) ? bus.wdata : sh;
			sd <= sh;
			hi <= gen ? ((hi == 3'h7) ? hi : hi + 3'h1) : 3'h0;
		end
	end
	sequence s_hold_rd;
		bus.rd && bus.addr == TCE_OFS_CNT_LO && sh[7:6] == 2'h0 && sh[23:22] == 2'h0;
	endsequence
	chk_unmapped_zero: assert property (bus.rd && bus.addr == 8'h30 |=> rdata == '0)
		else $error("unmapped read not zero");
	chk_rsvd_zero: assert property (bus.rd && bus.addr == TCE_OFS_CTRL |=> rdata[31:24] == '0 && rdata[21:9] == '0)
		else $error("reserved control bits not zero");
	chk_status_mirror: assert property (output_level_status == timer_out)
		else $error("status differs from pin");
	chk_status_read: assert property (bus.rd && bus.addr == TCE_OFS_CTRL |=> rdata[0] == $past(output_level_status))
		else $error("status bit read wrong");
	chk_ctrl_readback: assert property (bus.rd && bus.addr == TCE_OFS_CTRL |=> rdata[23:1] == (sd[23:1] & 23'h6000FF))
		else $error("control fields read wrong");
	chk_pulse_width: assert property ($fell(gen) && !sh[3] && !sh[8] && $stable(sh) |-> hi == {1'b0, sh[5:4]} + 3'h1)
		else $error("pulse width wrong");
	chk_clock_toggle: assert property (sh[3] && $stable(sh) && $changed(gen) |=> $stable(gen))
		else $error("clock mode level not held");
	chk_count_hold: assert property (s_hold_rd ##1 s_hold_rd |=> rdata == $past(rdata))
		else $error("stopped counter moved");
endmodule
bind tce_top tce_chk u_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .timer_in(timer_in),
	.timer_out(timer_out), .output_level_status(output_level_status));
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the timer control block.
// Drives the register port and timer pin directly.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tce_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic timer_in = 1'b0;
	tce_bus_t bus = '0;
	logic [TCE_DW-1:0] rdata;
	logic timer_out;
	logic output_level_status;
	int fails = 0;
	int compares = 0;
	logic [31:0] d1, d2, h;
	logic [31:0] p = 32'h2;
	logic [31:0] cv [10] = '{32'h02, 32'h42, 32'h82, 32'h92, 32'hA2, 32'hB2, 32'h82, 32'h82, 32'h8A, 32'h82};
	logic [1:0] gv [10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3};
	logic [31:0] ev [10] = '{32'h0, 32'h1, 32'h6, 32'hC, 32'h12, 32'h18, 32'h0, 32'h6, 32'h18, 32'h3};
	tce_top uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .timer_in(timer_in),
		.timer_out(timer_out), .output_level_status(output_level_status));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= {a, d, 2'b10};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd2(input logic [7:0] a, input int n, output logic [31:0] x, output logic [31:0] y);
		@(posedge clk);
		bus <= {a, 32'h0, 2'b01};
		@(posedge clk);
		if (n == 1) bus <= '0;
		#1 x = rdata;
		@(posedge clk);
		bus <= '0;
		#1 y = rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd2(a, 1, d1, d2);
		chk(d1, exp);
	endtask
	task automatic meas(input int s, output logic [31:0] n);
		n = '0;
		repeat (s) @(posedge clk);
		repeat (48) begin
			@(posedge clk);
			#1 n = n + {31'h0, timer_out};
		end
	endtask
	task automatic close_out();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdc(TCE_OFS_CTRL, 32'h1);
		chk({31'h0, timer_out}, 32'h1);
		rdc(8'h30, 32'h0);
		wr(TCE_OFS_CTRL, 32'hFFFF_FFFF);
		rdc(TCE_OFS_CTRL, 32'h00C0_01FE);
		wr(TCE_OFS_CNT_LO, 32'h5);
		for (int e = 0; e < 2; e++) begin
			wr(TCE_OFS_CTRL, e ? 32'hC2 : 32'h02);
			rd2(TCE_OFS_CNT_LO, 2, d1, d2);
			chk(d1, 32'h5);
			chk(d2, 32'h5);
		end
		wr(TCE_OFS_GCTRL, 32'h4);
		wr(TCE_OFS_PRD_LO, 32'h7);
		wr(TCE_OFS_CNT_LO, 32'h0);
		wr(TCE_OFS_CTRL, 32'h182);
		@(posedge clk) timer_in <= 1'b1;
		repeat (8) @(posedge clk);
		rdc(TCE_OFS_CNT_LO, 32'h1);
		wr(TCE_OFS_CNT_LO, 32'h0);
		wr(TCE_OFS_CTRL, 32'h186);
		@(posedge clk) timer_in <= 1'b0;
		repeat (8) @(posedge clk);
		rdc(TCE_OFS_CNT_LO, 32'h1);
		wr(TCE_OFS_GCTRL, 32'h0);
		wr(TCE_OFS_CTRL, 32'h0080_0002);
		wr(TCE_OFS_PRD_HI, 32'h64);
		wr(TCE_OFS_CNT_HI, 32'h0);
		rd2(TCE_OFS_CNT_HI, 2, d1, d2);
		chk(d2, 32'h0);
		wr(TCE_OFS_GCTRL, 32'h4);
		rd2(TCE_OFS_CNT_HI, 2, d1, d2);
		chk(d1, 32'h1);
		chk(d2, 32'h2);
		wr(TCE_OFS_CTRL, 32'h2);
		wr(TCE_OFS_PRD_HI, 32'h0);
		wr(TCE_OFS_CNT_HI, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wr(TCE_OFS_CTRL, p & 32'hFFFF_FF3F);
			repeat (8) @(posedge clk);
			// Chained pass: upper half counts lower matches against period 1
			if (i == 9) wr(TCE_OFS_PRD_HI, 32'h1);
			wr(TCE_OFS_GCTRL, {28'h0, gv[i], 2'h0});
			wr(TCE_OFS_CNT_LO, 32'h0);
			wr(TCE_OFS_CTRL, cv[i]);
			p = cv[i];
			meas((cv[i][7:6] == 2'h2) ? 16 : 0, h);
			chk(h, ev[i]);
		end
		// Reset in mid-run returns counters, control and pin to idle
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(TCE_OFS_CNT_LO, 32'h0);
		rdc(TCE_OFS_CTRL, 32'h1);
		chk({31'h0, timer_out}, 32'h1);
		close_out();
	end
endmodule
`default_nettype wire
